// ==== logic/gpwk_pkg.sv ====
// Purpose: Shared constants and types for the seven-port GPIO block with wake-up
// Assumes: Byte-wide data memory access from the processor core
// Notes: Register indices are word addresses on the core's data memory port
package gpwk_pkg;
    localparam int GPWK_PORTS = 7;
    localparam int GPWK_PINS = 8;
    // Register slots within a port group (port group base = port * 4)
    localparam logic [7:0] GPWK_SLOT_DATA = 8'h00;
    localparam logic [7:0] GPWK_SLOT_DIR = 8'h01;
    localparam logic [7:0] GPWK_SLOT_PULL = 8'h02;
    localparam logic [7:0] GPWK_SLOT_WAKE = 8'h03;
    localparam logic [7:0] GPWK_GROUP_STRIDE = 8'h04;
    // Port A slot 3 holds the low edge register; the high one sits after port G
    localparam logic [7:0] GPWK_ADDR_EDGE_LOW = 8'h03;
    localparam logic [7:0] GPWK_ADDR_EDGE_HIGH = 8'h1C;
    localparam logic [7:0] GPWK_ADDR_LAST = 8'h1C;
    // Port index of the one port with a missing pin
    localparam int GPWK_PORT_E = 4;
    localparam logic [7:0] GPWK_MASK_FULL = 8'hFF;
    localparam logic [7:0] GPWK_MASK_PORT_E = 8'hFD;
    // Reset values
    localparam logic [7:0] GPWK_RST_REG = 8'h00;
    // Two-bit edge codes for port A wake-up
    localparam logic [1:0] GPWK_EDGE_OFF = 2'h0;
    localparam logic [1:0] GPWK_EDGE_RISE = 2'h1;
    localparam logic [1:0] GPWK_EDGE_FALL = 2'h2;
    localparam logic [1:0] GPWK_EDGE_BOTH = 2'h3;

    typedef enum logic {GPWK_RUN, GPWK_SLEEP} gpwk_mode_t;

    typedef logic [GPWK_PORTS-1:0][GPWK_PINS-1:0] gpwk_bank_t;

    // Software-visible configuration
    typedef struct packed {
        gpwk_bank_t data;
        gpwk_bank_t dir;
        gpwk_bank_t pull;
        gpwk_bank_t wake;
        logic [7:0] edge_low;
        logic [7:0] edge_high;
    } gpwk_cfg_t;

    // Pin-facing outputs, all registered
    typedef struct packed {
        gpwk_bank_t level;
        gpwk_bank_t drive_en;
        gpwk_bank_t pull_en;
    } gpwk_pad_t;
endpackage

// ==== logic/gpwk_ports.sv ====
// Purpose: Seven 8-bit general purpose ports with pull-ups and pin wake-up
// Assumes: Pin inputs and core strobes synchronous to clk_sys_i
// Notes: Read data appears one cycle after the read strobe
//
// Behaviour
// RQ1: Data latch bit sets the level driven on an output pin.
// RQ2: Direction bit 0 makes pin push-pull output, 1 makes it input.
// RQ3: Pull-up bit 1 enables the weak pull-up, 0 disables it.
// RQ4: Wake enable bit per pin on ports B to G turns wake-up on.
// RQ5: Reading an input pin samples its live level at the read edge.
// RQ6: The external source holds the input level stable at the read edge.
// RQ7: Data latch holds its value until software writes it again.
// RQ8: Pull-up acts only for input or open-drain pins, else stays off.
// RQ9: Wake-up acts only in GPIO function and while powered down.
// RQ10: Falling edge on enabled port B to G pin requests wake-up.
// RQ11: Port A pin wakes on rising, falling or both per selection.
// RQ12: Port A polarity is per pin across two edge registers.
// RQ13: Unimplemented bits, port E bit 1 included, ignore writes, read 0.
// RQ14: Halt enters sleep; a qualifying pin wake-up ends it.
// RQ15: Port A edge code 00 off, 01 rise, 10 fall, 11 both.
// RQ16: Reading an output pin returns its latch, not the pin level.
// RQ17: Pins pass two synchroniser stages before wake edge detection.
// RQ18: All configuration registers reset to zero.
`timescale 1ns/1ps
module gpwk_ports
    import gpwk_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Core data memory port
    input wire logic [7:0] mem_addr_i,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    // Power control
    input wire logic halt_i,
    output logic sleep_o,
    output logic wake_req_o,
    // Pin-sharing state from the function selector
    input wire gpwk_bank_t gpio_sel_i,
    input wire gpwk_bank_t open_drain_i,
    // Pads
    input wire gpwk_bank_t pin_i,
    output gpwk_bank_t pin_o,
    output gpwk_bank_t pin_oe_o,
    output gpwk_bank_t pullup_en_o
);

    // Whole module state in one record
    typedef struct packed {
        gpwk_cfg_t cfg;
        gpwk_bank_t sync_a;
        gpwk_bank_t sync_b;
        gpwk_bank_t prev;
        gpwk_pad_t pad;
        logic [7:0] rdata;
        logic wake;
        gpwk_mode_t mode;
    } gpwk_state_t;

    gpwk_state_t state_ff;
    gpwk_state_t nxt_state;

    // Implemented-bit mask of a port
    function automatic logic [7:0] gpwk_mask(input int port);
        return (port == GPWK_PORT_E) ? GPWK_MASK_PORT_E : GPWK_MASK_FULL;
    endfunction

    // Port A edge match for one pin
    function automatic logic gpwk_edge_hit(input logic [1:0] code, input logic old_lvl,
                                           input logic new_lvl);
        logic rise;
        logic fall;
        rise = !old_lvl && new_lvl;
        fall = old_lvl && !new_lvl;
        case (code)
            GPWK_EDGE_RISE: return rise; // RQ15
            GPWK_EDGE_FALL: return fall; // RQ15
            GPWK_EDGE_BOTH: return rise || fall; // RQ15
            default: return 1'b0; // RQ15
        endcase
    endfunction

    // Next-state logic
    always_comb begin
        logic [7:0] wbits;
        logic [7:0] rbits;
        logic [15:0] codes;
        logic hit;
        logic [7:0] base;
        wbits = 8'h00;
        rbits = 8'h00;
        codes = 16'h0000;
        hit = 1'b0;
        base = 8'h00;
        nxt_state = state_ff;

        // Register writes; masked bits never store
        for (int p = 0; p < GPWK_PORTS; p++) begin
            base = 8'(p) * GPWK_GROUP_STRIDE;
            wbits = mem_wdata_i & gpwk_mask(p); // RQ13
            if (mem_wr_i && mem_addr_i == base + GPWK_SLOT_DATA) begin
                nxt_state.cfg.data[p] = wbits; // RQ1 RQ7
            end
            if (mem_wr_i && mem_addr_i == base + GPWK_SLOT_DIR) begin
                nxt_state.cfg.dir[p] = wbits; // RQ2
            end
            if (mem_wr_i && mem_addr_i == base + GPWK_SLOT_PULL) begin
                nxt_state.cfg.pull[p] = wbits; // RQ3
            end
            if (p != 0 && mem_wr_i && mem_addr_i == base + GPWK_SLOT_WAKE) begin
                nxt_state.cfg.wake[p] = wbits; // RQ4
            end
        end
        if (mem_wr_i && mem_addr_i == GPWK_ADDR_EDGE_LOW) begin
            nxt_state.cfg.edge_low = mem_wdata_i; // RQ12
        end
        if (mem_wr_i && mem_addr_i == GPWK_ADDR_EDGE_HIGH) begin
            nxt_state.cfg.edge_high = mem_wdata_i; // RQ12
        end

        // Read mux; inputs come live from the pad, outputs from the latch
        for (int p = 0; p < GPWK_PORTS; p++) begin
            base = 8'(p) * GPWK_GROUP_STRIDE;
            if (mem_addr_i == base + GPWK_SLOT_DATA) begin
                rbits = (state_ff.cfg.dir[p] & pin_i[p]) |
                        (~state_ff.cfg.dir[p] & state_ff.cfg.data[p]); // RQ5 RQ16
            end else if (mem_addr_i == base + GPWK_SLOT_DIR) begin
                rbits = state_ff.cfg.dir[p];
            end else if (mem_addr_i == base + GPWK_SLOT_PULL) begin
                rbits = state_ff.cfg.pull[p];
            end else if (p != 0 && mem_addr_i == base + GPWK_SLOT_WAKE) begin
                rbits = state_ff.cfg.wake[p];
            end
        end
        if (mem_addr_i == GPWK_ADDR_EDGE_LOW) begin
            rbits = state_ff.cfg.edge_low;
        end
        if (mem_addr_i == GPWK_ADDR_EDGE_HIGH) begin
            rbits = state_ff.cfg.edge_high;
        end
        // Unmapped addresses read zero; data held between reads
        if (mem_rd_i) begin
            nxt_state.rdata = (mem_addr_i > GPWK_ADDR_LAST) ? 8'h00 : rbits; // RQ13
        end

        // Two-stage synchroniser, edges taken only past the second stage
        nxt_state.sync_a = pin_i; // RQ17
        nxt_state.sync_b = state_ff.sync_a; // RQ17
        nxt_state.prev = state_ff.sync_b; // RQ17

        // Wake-up detection, gated by GPIO function and sleep
        codes = {state_ff.cfg.edge_high, state_ff.cfg.edge_low};
        for (int i = 0; i < GPWK_PINS; i++) begin
            if (gpio_sel_i[0][i] &&
                gpwk_edge_hit(codes[2*i +: 2], state_ff.prev[0][i], state_ff.sync_b[0][i])) begin
                hit = 1'b1; // RQ11
            end
        end
        for (int p = 1; p < GPWK_PORTS; p++) begin
            if (|(state_ff.cfg.wake[p] & gpio_sel_i[p] &
                  state_ff.prev[p] & ~state_ff.sync_b[p])) begin
                hit = 1'b1; // RQ10 RQ4
            end
        end
        // Request only while powered down; a pulse of one cycle
        nxt_state.wake = hit && (state_ff.mode == GPWK_SLEEP); // RQ9

        // Sleep state; wake beats a halt in the same cycle
        case (state_ff.mode)
            GPWK_RUN: begin
                if (halt_i) begin
                    nxt_state.mode = GPWK_SLEEP; // RQ14
                end
            end
            GPWK_SLEEP: begin
                if (nxt_state.wake) begin
                    nxt_state.mode = GPWK_RUN; // RQ14
                end
            end
            default: begin
                nxt_state.mode = GPWK_RUN;
            end
        endcase

        // Pad drive from the new configuration so pins follow writes at once
        nxt_state.pad.level = nxt_state.cfg.data; // RQ1
        for (int p = 0; p < GPWK_PORTS; p++) begin
            nxt_state.pad.drive_en[p] = ~nxt_state.cfg.dir[p] & gpwk_mask(p); // RQ2
            // Pull-up would fight a push-pull driver, so only inputs or open-drain
            nxt_state.pad.pull_en[p] = nxt_state.cfg.pull[p] &
                (nxt_state.cfg.dir[p] | open_drain_i[p]) & gpwk_mask(p); // RQ3 RQ8
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= '0; // RQ18
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flip-flops
    assign mem_rdata_o = state_ff.rdata;
    assign sleep_o = (state_ff.mode == GPWK_SLEEP);
    assign wake_req_o = state_ff.wake;
    assign pin_o = state_ff.pad.level;
    assign pin_oe_o = state_ff.pad.drive_en;
    assign pullup_en_o = state_ff.pad.pull_en;

endmodule // gpwk_ports

// ==== verif/gpwk_checker.sv ====
// Purpose: Assertions on the port block pins
// Assumes: Bound into gpwk_ports
// Notes: Write checks use port A slots only
`timescale 1ns/1ps
module gpwk_checker
    import gpwk_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic mem_wr_i,
    input wire logic [7:0] mem_wdata_i,
    // Power and pads
    input wire logic halt_i,
    input wire logic sleep_o,
    input wire logic wake_req_o,
    input wire gpwk_bank_t open_drain_i,
    input wire gpwk_bank_t pin_o,
    input wire gpwk_bank_t pin_oe_o,
    input wire gpwk_bank_t pullup_en_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // Halt taken while running
    sequence s_halt;
        halt_i && !sleep_o;
    endsequence
    // Wake pulse ends the sleep in the same cycle
    sequence s_wake_end;
        !sleep_o && $past(sleep_o);
    endsequence
    property p_halt_sleep;
        s_halt |=> sleep_o;
    endproperty
    a_halt_sleep: assert property (p_halt_sleep) else $error("halt did not sleep");
    property p_wake_ends;
        wake_req_o |-> s_wake_end;
    endproperty
    a_wake_ends: assert property (p_wake_ends) else $error("wake without sleep");
    property p_wake_pulse;
        wake_req_o |=> !wake_req_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
    property p_sleep_fell;
        $fell(sleep_o) |-> wake_req_o;
    endproperty
    a_sleep_fell: assert property (p_sleep_fell) else $error("left sleep alone");
    // Output pins never pulled unless open drain
    property p_pull_off;
        (pullup_en_o & pin_oe_o & ~$past(open_drain_i)) == '0;
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull on output");
    property p_latch_hold;
        !$past(mem_wr_i) |-> $stable(pin_o);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
    property p_wr_data;
        mem_wr_i && mem_addr_i == GPWK_SLOT_DATA |=> pin_o[0] == $past(mem_wdata_i);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("data not driven");
    property p_wr_dir;
        mem_wr_i && mem_addr_i == GPWK_SLOT_DIR |=> pin_oe_o[0] == ~$past(mem_wdata_i);
    endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("direction wrong");
    property p_gap;
        !pin_oe_o[GPWK_PORT_E][1] && !pullup_en_o[GPWK_PORT_E][1];
    endproperty
    a_gap: assert property (p_gap) else $error("missing pin active");
endmodule // gpwk_checker
bind gpwk_ports gpwk_checker u_chk(.clk_sys_i, .rst_i, .mem_addr_i, .mem_wr_i, .mem_wdata_i,
    .halt_i, .sleep_o, .wake_req_o, .open_drain_i, .pin_o, .pin_oe_o, .pullup_en_o);

// ==== verif/gpwk_pin_model.sv ====
// Purpose: Switches and weak pull-ups on the pads
// Assumes: Bench moves switches at falling edges
// Notes: Floating lines toggle every cycle; open-drain highs release the line
`timescale 1ns/1ps
module gpwk_pin_model
    import gpwk_pkg::*;
(
    // Clock and pads
    input wire logic clk_sys_i,
    input wire gpwk_bank_t pin_o,
    input wire gpwk_bank_t pin_oe_o,
    input wire gpwk_bank_t pullup_en_o,
    input wire gpwk_bank_t open_drain_i,
    // Switch settings
    input wire gpwk_bank_t sw_en_i,
    input wire gpwk_bank_t sw_lvl_i,
    output gpwk_bank_t pad_o
);
    gpwk_bank_t float_ff = '0;
    gpwk_bank_t drv;
    // Open lines keep no level worth trusting
    always_ff @(negedge clk_sys_i) float_ff <= ~float_ff;
    // Driver first, then switch, then pull-up; stable at rising edges
    // Open-drain pins only sink; a high latch leaves the line to the far side
    assign drv = pin_oe_o & ~(open_drain_i & pin_o);
    assign pad_o = (drv & pin_o) | (~drv & sw_en_i & sw_lvl_i)
        | (~drv & ~sw_en_i & (pullup_en_o | float_ff));
endmodule // gpwk_pin_model

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the port block
// Assumes: Inputs change at falling edges
// Notes: Ports A, C and D carry switches
`timescale 1ns/1ps
module testbench;
    import gpwk_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, mem_wr_i = 1'b0, mem_rd_i = 1'b0, halt_i = 1'b0;
    logic sleep_o, wake_req_o;
    logic [7:0] mem_addr_i = '0, mem_wdata_i = '0, mem_rdata_o;
    gpwk_bank_t gpio_sel_i = '1, open_drain_i = '0, pin_i, pin_o, pin_oe_o, pullup_en_o;
    gpwk_bank_t sw_en = 56'h000000FFFF00FF, sw_lvl = '1;
    int err_total = 0, checks_done = 0;
    gpwk_ports uut(.clk_sys_i, .rst_i, .mem_addr_i, .mem_wr_i, .mem_rd_i, .mem_wdata_i,
        .mem_rdata_o, .halt_i, .sleep_o, .wake_req_o, .gpio_sel_i, .open_drain_i, .pin_i,
        .pin_o, .pin_oe_o, .pullup_en_o);
    gpwk_pin_model u_pins(.clk_sys_i, .pin_o, .pin_oe_o, .pullup_en_o, .open_drain_i,
        .sw_en_i(sw_en),
        .sw_lvl_i(sw_lvl), .pad_o(pin_i));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    task automatic check(input string nm, input logic [7:0] seen, ex);
        checks_done++;
        if (seen !== ex) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk_sys_i);
        mem_addr_i = a;
        mem_wdata_i = d;
        mem_wr_i = 1'b1;
        @(negedge clk_sys_i);
        mem_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, ex);
        @(negedge clk_sys_i);
        mem_addr_i = a;
        mem_rd_i = 1'b1;
        @(negedge clk_sys_i);
        mem_rd_i = 1'b0;
        check("mem_rdata_o", mem_rdata_o, ex);
    endtask
    // Sleep if awake, move one switch, look for the wake pulse
    task automatic try_wake(input logic [7:0] a, v, input int p, n, input logic lv, ex);
        logic seen = 1'b0;
        wr(a, v);
        if (sleep_o !== 1'b1) begin
            halt_i = 1'b1;
            @(negedge clk_sys_i);
            halt_i = 1'b0;
        end
        repeat (2) @(negedge clk_sys_i);
        sw_lvl[p][n] = lv;
        repeat (8) begin
            @(negedge clk_sys_i);
            seen |= wake_req_o;
        end
        check("wake_req_o", {7'h00, seen}, {7'h00, ex});
        check("sleep_o", {7'h00, sleep_o}, {7'h00, ~ex});
    endtask
    task automatic t_reset;
        for (int a = 0; a <= 28; a++) rd(a[7:0], 8'h00);
        for (int p = 0; p < GPWK_PORTS; p++) begin
            check("pin_oe_o", pin_oe_o[p], p == GPWK_PORT_E ? GPWK_MASK_PORT_E : 8'hFF);
            check("pullup_en_o", pullup_en_o[p], 8'h00);
        end
    endtask
    // All ones everywhere, one address past the map
    task automatic t_regs;
        for (int a = 0; a <= 29; a++) wr(a[7:0], 8'hFF);
        for (int a = 0; a <= 29; a++)
            rd(a[7:0], a > 28 ? 8'h00 : a / 4 == GPWK_PORT_E ? GPWK_MASK_PORT_E : 8'hFF);
        check("pullup_en_o", pullup_en_o[1], 8'hFF);
    endtask
    task automatic t_output;
        wr(8'h05, 8'h00);
        wr(8'h04, 8'h5A);
        check("pin_o", pin_o[1], 8'h5A);
        check("pin_oe_o", pin_oe_o[1], 8'hFF);
        rd(8'h04, 8'h5A);
        wr(8'h06, 8'h3C);
        check("pullup_en_o", pullup_en_o[1], 8'h00);
        check("pin_o", pin_o[1], 8'h5A);
        open_drain_i[1] = 8'hF0;
        repeat (2) @(negedge clk_sys_i);
        check("pullup_en_o", pullup_en_o[1], 8'h30);
        // Back to push-pull so no released line floats during sleep
        open_drain_i[1] = 8'h00;
    endtask
    task automatic t_input;
        wr(8'h0A, 8'h00);
        sw_lvl[2] = 8'h3C;
        rd(8'h08, 8'h3C);
        sw_lvl[2] = 8'hC3;
        rd(8'h08, 8'hC3);
        check("pin_oe_o", pin_oe_o[2], 8'h00);
        // Released open-drain highs show the switches; the read must show the latch
        open_drain_i[2] = 8'hFF;
        wr(8'h09, 8'h00);
        rd(8'h08, 8'hFF);
        wr(8'h09, 8'hFF);
        open_drain_i[2] = 8'h00;
    endtask
    task automatic t_wake;
        try_wake(8'h0F, 8'h01, 3, 0, 1'b0, 1'b1);
        try_wake(8'h0F, 8'h00, 3, 0, 1'b1, 1'b0);
        try_wake(8'h0F, 8'h00, 3, 0, 1'b0, 1'b0);
        try_wake(8'h03, 8'h02, 0, 0, 1'b0, 1'b1);
        try_wake(8'h03, 8'h01, 0, 0, 1'b1, 1'b1);
        try_wake(8'h03, 8'h01, 0, 0, 1'b0, 1'b0);
        try_wake(8'h03, 8'h00, 0, 0, 1'b1, 1'b0);
        try_wake(8'h03, 8'h03, 0, 0, 1'b0, 1'b1);
        try_wake(8'h03, 8'h03, 0, 0, 1'b1, 1'b1);
        try_wake(8'h1C, 8'h02, 0, 4, 1'b0, 1'b1);
        // Rising edge on an enabled port D pin must not wake
        try_wake(8'h0F, 8'h01, 3, 0, 1'b1, 1'b0);
        // Falling edge on a pin taken by another function must not wake
        gpio_sel_i[3][0] = 1'b0;
        try_wake(8'h0F, 8'h01, 3, 0, 1'b0, 1'b0);
        gpio_sel_i[3][0] = 1'b1;
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rst_i = 0;
        t_reset();
        t_regs();
        t_output();
        t_input();
        t_wake();
        finish_test();
    end
    // Run needs well under 2000 cycles
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule // testbench
